/* File: src/mcf_counter.sv */
`timescale 1ns/1ps
`include "mcf_regs.svh"

// Behaviour
// - count is 16 bits in low half; upper 16 bits read zero
// - add one per successful frame sent after two or more collisions
// - only transmit frames increment the count; receive never does
// - any mapped read clears count, unless byte enables 0 and 1 both low

module mcf_counter
    import mcf_pkg::*;
(
    input wire logic pclk, // clock, 40 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [`MCF_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte enables
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic tx_done, // transmit frame end pulse
    input wire logic tx_ok, // frame transmitted successfully
    input wire logic [4:0] tx_coll_cnt, // collisions of the ending frame
    output logic [`MCF_CNT_W-1:0] count_out // live count value
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [`MCF_CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic bump;
    logic setup, hit;
    mcf_alias_t op;
    logic [`MCF_CNT_W-1:0] wmask, wval;

    // only the transmit engine drives the increment; no receive input exists
    mcf_frame_qual u_qual (
        .pclk(pclk),
        .presetn(presetn),
        .tx_done(tx_done),
        .tx_ok(tx_ok),
        .tx_coll_cnt(tx_coll_cnt),
        .bump_q(bump)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // one wait state: answer in the cycle after the access phase begins
    assign setup = psel && penable && !pready_q;
    assign hit = (paddr == `MCF_OFS_COUNT) || (paddr == `MCF_OFS_CLR) ||
                 (paddr == `MCF_OFS_SET) || (paddr == `MCF_OFS_INV);

    always_comb begin
        case (paddr)
            `MCF_OFS_CLR: op = MCF_OP_CLR;
            `MCF_OFS_SET: op = MCF_OP_SET;
            `MCF_OFS_INV: op = MCF_OP_INV;
            default: op = MCF_OP_NONE;
        endcase
        wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wval = pwdata[`MCF_CNT_W-1:0];
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (setup && hit && pwrite) begin
            case (op)
                MCF_OP_NONE: cnt_d = (cnt_q & ~wmask) | (wval & wmask);
                MCF_OP_SET: cnt_d = cnt_q | (wval & wmask);
                MCF_OP_CLR: cnt_d = cnt_q & ~(wval & wmask);
                MCF_OP_INV: cnt_d = cnt_q ^ (wval & wmask);
                default: cnt_d = cnt_q;
            endcase
        end else if (setup && hit && !pwrite && (pstrb[1] || pstrb[0])) begin
            // an increment landing on the clearing read is kept, not lost
            cnt_d = {{(`MCF_CNT_W-1){1'b0}}, bump};
        end else if (bump) begin
            cnt_d = cnt_q + 16'h0001;
        end
        // a frame landing on a write is counted on top of the written value
        if (setup && hit && pwrite && bump) begin
            cnt_d = cnt_d + 16'h0001;
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_comb begin
        pready_d = setup;
        pslverr_d = setup && !hit;
        prdata_d = 32'h0000_0000;
        if (setup && hit && !pwrite) begin
            prdata_d = {16'h0000, cnt_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `MCF_CNT_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign count_out = cnt_q;

    // ----------------------------------------
    // access steps for the checks
    // ----------------------------------------
    // a read with a low byte lane on, which clears
    sequence s_clear_read;
        setup && hit && !pwrite && (pstrb[1:0] != 2'b00);
    endsequence

    // a mapped write that covers the whole count
    sequence s_full_write;
        setup && hit && pwrite && (pstrb[1:0] == 2'b11);
    endsequence

    // an access to an address that holds nothing
    sequence s_refused;
        setup && !hit;
    endsequence

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");

    AST_READ_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && hit && !pwrite) |=> prdata == {16'h0000, $past(cnt_q)})
        else $error("read data is not the count before the access");

    AST_INCREMENT: assert property (@(posedge pclk) disable iff (!presetn)
        (bump && !setup) |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("qualified frame did not add one");

    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        (bump && !setup && cnt_q == 16'hffff) |=> cnt_q == 16'h0000)
        else $error("full count did not wrap to zero");

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!bump && !setup) |=> $stable(cnt_q))
        else $error("count changed with no transmit event or access");

    AST_READ_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (s_clear_read ##0 !bump) |=> cnt_q == 16'h0000)
        else $error("read did not clear count");

    AST_READ_BUMP: assert property (@(posedge pclk) disable iff (!presetn)
        (s_clear_read ##0 bump) |=> cnt_q == 16'h0001)
        else $error("frame landing on a clearing read was lost");

    AST_READ_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && pstrb[1:0] == 2'b00 && !bump) |=> $stable(cnt_q))
        else $error("read with low lanes off changed count");

    AST_PLAIN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (s_full_write ##0 (paddr == `MCF_OFS_COUNT && !bump))
        |=> cnt_q == $past(pwdata[15:0]))
        else $error("plain write did not load the count");

    AST_WRITE_BUMP: assert property (@(posedge pclk) disable iff (!presetn)
        (s_full_write ##0 (paddr == `MCF_OFS_COUNT && bump))
        |=> cnt_q == $past(pwdata[15:0]) + 16'h0001)
        else $error("frame landing on a write was lost");

    AST_SET_ALIAS: assert property (@(posedge pclk) disable iff (!presetn)
        (s_full_write ##0 (paddr == `MCF_OFS_SET && !bump))
        |=> cnt_q == ($past(cnt_q) | $past(pwdata[15:0])))
        else $error("set alias did not or bits in");

    AST_CLR_ALIAS: assert property (@(posedge pclk) disable iff (!presetn)
        (s_full_write ##0 (paddr == `MCF_OFS_CLR && !bump))
        |=> cnt_q == ($past(cnt_q) & ~$past(pwdata[15:0])))
        else $error("clear alias did not clear bits");

    AST_INV_ALIAS: assert property (@(posedge pclk) disable iff (!presetn)
        (s_full_write ##0 (paddr == `MCF_OFS_INV && !bump))
        |=> cnt_q == ($past(cnt_q) ^ $past(pwdata[15:0])))
        else $error("invert alias did not toggle bits");

    AST_REFUSED: assert property (@(posedge pclk) disable iff (!presetn)
        (s_refused ##0 !bump) |=> (pslverr && prdata == 32'h0000_0000 && $stable(cnt_q)))
        else $error("unmapped access not refused cleanly");

    AST_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("ready not one cycle after access phase began");

    AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held more than one cycle");

    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error shown without ready");

    AST_IDLE_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside an answer");
endmodule

/* File: src/mcf_regs.svh */
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define MCF_ADDR_W 12
`define MCF_OFS_COUNT 12'h000
`define MCF_OFS_CLR 12'h004
`define MCF_OFS_SET 12'h008
`define MCF_OFS_INV 12'h00c

// ----------------------------------------
// field layout and reset
// ----------------------------------------
`define MCF_CNT_W 16
`define MCF_CNT_RESET 16'h0000
`define MCF_MIN_COLL 5'h02

`endif

/* File: src/mcf_pkg.sv */
package mcf_pkg;
    typedef enum logic [3:0] {
        MCF_OP_NONE = 4'b0001,
        MCF_OP_CLR = 4'b0010,
        MCF_OP_SET = 4'b0100,
        MCF_OP_INV = 4'b1000
    } mcf_alias_t;
endpackage

/* File: src/mcf_frame_qual.sv */
`timescale 1ns/1ps
`include "mcf_regs.svh"

module mcf_frame_qual
    import mcf_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic tx_done, // transmit frame finished, pulse
    input wire logic tx_ok, // frame sent successfully
    input wire logic [4:0] tx_coll_cnt, // collisions seen by the frame
    output logic bump_q // one-cycle increment request
);
    logic bump_d;

    always_comb begin
        bump_d = tx_done && tx_ok && (tx_coll_cnt >= `MCF_MIN_COLL);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bump_q <= 1'b0;
        end else begin
            bump_q <= bump_d;
        end
    end

    AST_QUAL_ONE_COLL: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_done && tx_coll_cnt < `MCF_MIN_COLL) |=> !bump_q)
        else $error("frame with under two collisions counted");

    AST_QUAL_FAILED: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_done && !tx_ok) |=> !bump_q)
        else $error("failed frame counted");

    AST_QUAL_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_done && tx_ok && tx_coll_cnt >= `MCF_MIN_COLL) |=> bump_q)
        else $error("qualified frame not passed on");
endmodule

/* File: dv/mcf_tx_model.sv */
`timescale 1ns/1ps
module mcf_tx_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic go, // end a frame now
    input wire logic ok_in, // frame outcome
    input wire logic [4:0] coll_in, // collisions
    output logic tx_done, // end pulse
    output logic tx_ok, // valid with pulse
    output logic [4:0] tx_coll_cnt // valid with pulse
);
    // idle lines toggle so a stale value never passes as valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done <= 1'b0;
            tx_ok <= 1'b0;
            tx_coll_cnt <= 5'h00;
        end else begin
            tx_done <= go;
            tx_ok <= go ? ok_in : ~tx_ok;
            tx_coll_cnt <= go ? coll_in : ~tx_coll_cnt;
        end
    end
endmodule

/* File: dv/mcf_counter_tb_top.sv */
`timescale 1ns/1ps
`include "mcf_regs.svh"
module mcf_counter_tb_top;
    import mcf_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go = 1'b0, ok_in = 1'b0;
    logic [4:0] coll_in = 5'h00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, tx_done, tx_ok, er;
    logic [4:0] tx_coll_cnt;
    logic [15:0] count_out;
    int n_errors = 0, checked = 0;
    initial forever #12.5 pclk = ~pclk;
    mcf_tx_model i_mcf_tx_model (.pclk(pclk), .presetn(presetn), .go(go), .ok_in(ok_in),
        .coll_in(coll_in), .tx_done(tx_done), .tx_ok(tx_ok), .tx_coll_cnt(tx_coll_cnt));
    mcf_counter i_mcf_counter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_done(tx_done), .tx_ok(tx_ok),
        .tx_coll_cnt(tx_coll_cnt), .count_out(count_out));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task frame(input logic ok, input logic [4:0] c);
        go <= 1'b1;
        ok_in <= ok;
        coll_in <= c;
        @(posedge pclk);
        go <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task frame_apb(input logic w, input logic [31:0] d, input logic [3:0] s);
        go <= 1'b1;
        ok_in <= 1'b1;
        coll_in <= 5'h02;
        @(posedge pclk);
        go <= 1'b0;
        apb(w, `MCF_OFS_COUNT, d, s);
    endtask
    task summarize;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge pclk);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("reset value", 32'h0, rd);
        frame(1'b1, 5'h00);
        frame(1'b1, 5'h01);
        frame(1'b1, 5'h02);
        frame(1'b0, 5'h05);
        frame(1'b1, 5'h1f);
        chk("live count", 32'h2, {16'h0, count_out});
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'hc);
        chk("read lanes 2,3", 32'h2, rd);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h1);
        chk("clearing read", 32'h2, rd);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("after clear", 32'h0, rd);
        apb(1'b1, `MCF_OFS_COUNT, 32'hffff1234, 4'hf);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("upper half", 32'h1234, rd);
        apb(1'b1, `MCF_OFS_SET, 32'h000000c1, 4'hf);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("set alias", 32'h12f5, rd);
        apb(1'b1, `MCF_OFS_CLR, 32'h00000005, 4'hf);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("clear alias", 32'h12f0, rd);
        apb(1'b1, `MCF_OFS_INV, 32'h000000ff, 4'hf);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("invert alias", 32'h120f, rd);
        apb(1'b1, 12'h010, 32'h0, 4'hf);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h2);
        chk("unmapped no effect", 32'h120f, rd);
        apb(1'b1, `MCF_OFS_COUNT, 32'h0000ffff, 4'hf);
        frame(1'b1, 5'h03);
        chk("wrap", 32'h0, {16'h0, count_out});
        frame_apb(1'b1, 32'h00000010, 4'hf);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("write with frame", 32'h11, rd);
        frame_apb(1'b0, 32'h0, 4'h3);
        chk("read with frame", 32'h11, rd);
        apb(1'b0, `MCF_OFS_COUNT, 32'h0, 4'h0);
        chk("frame kept on clear", 32'h1, rd);
        summarize();
    end
endmodule
